// file: rtl/fbh_defs.vh
// Purpose: Constants for the parallel flash bus host controller.
// Assumes: Included by its bare name; 250 MHz aclk.
// Notes: Register offsets and bit positions are local choices of this block.
// Overview of operation
// - Read: select low, output enable low, strobe high.
// - Write: strobe and select low, output enable high.
// - Protect: A6 low, A1 high, A0 low.
// - Unprotect: same conditions but A6 high.
`ifndef FBH_DEFS_VH
`define FBH_DEFS_VH
`define FBH_REG_CTRL 8'h00
`define FBH_REG_ADDR 8'h04
`define FBH_REG_WDATA 8'h08
`define FBH_REG_RDATA 8'h0c
`define FBH_REG_STATUS 8'h10
`define FBH_CTRL_GO 0
`define FBH_CTRL_WRITE 1
`define FBH_CTRL_WORD 2
`define FBH_CTRL_HV 3
`define FBH_CTRL_RESET 4
`define FBH_CTRL_PROT 5
`define FBH_CTRL_UNPROT 6
`define FBH_ADDR_A6 7
`define FBH_ADDR_A1 2
`define FBH_ADDR_A0 1
`define FBH_PULSE_NS 120
`define FBH_CLK_NS 4
`define FBH_PULSE_CYC ((`FBH_PULSE_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_RESP_OKAY 2'b00
`define FBH_RESP_SLVERR 2'b10
`endif

// file: rtl/fbh_host.v
// Purpose: AXI4-Lite driven host that runs read, write, reset and protect cycles on a parallel flash.
// Assumes: aclk at 250 MHz; device pins sampled synchronously.
// Notes: One bus cycle at a time; software polls the busy bit before issuing another.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fbh_defs.vh"
module fbh_host #(
	parameter PULSE_CYC = `FBH_PULSE_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output wire s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output wire s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output wire s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	output reg [17:0] flash_addr,
	output reg chip_select_n,
	output reg output_enable_n,
	output reg write_strobe_n,
	output reg hw_reset_n,
	output reg high_identification_voltage,
	output reg width_select_n,
	input wire [14:0] dq_in,
	output reg [14:0] dq_out,
	output reg [14:0] dq_oe,
	input wire dq15_or_lsb_addr_in,
	output reg dq15_or_lsb_addr_out,
	output reg dq15_or_lsb_addr_oe
);
	// Bus cycle states.
	localparam ST_IDLE = 2'd0;
	localparam ST_PULSE = 2'd1;
	localparam ST_DONE = 2'd2;
	reg [1:0] state_r;
	reg [6:0] ctrl_r; // Software control word.
	reg [18:0] addr_r; // Byte address; bit 0 is the extra low bit in byte mode.
	reg [15:0] wdata_r; // Data for write cycles.
	reg [15:0] rdata_r; // Data captured at the end of a read.
	reg [15:0] cnt_r; // Strobe width counter.
	reg aw_seen_r; // Write address held until the data arrives.
	reg [7:0] awaddr_r;
	reg w_seen_r; // Write data held until the address arrives.
	reg [31:0] wdata_hold_r;
	wire busy = (state_r != ST_IDLE);
	wire wr_fire = aw_seen_r && w_seen_r && !s_bvalid;
	assign s_awready = !aw_seen_r && !s_bvalid;
	assign s_wready = !w_seen_r && !s_bvalid;
	assign s_arready = !s_rvalid;
	// Width select follows the control word; word mode is high.
	wire word_mode = ctrl_r[`FBH_CTRL_WORD];
	// AXI write channel: address and data taken in either order, response follows both.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_seen_r <= 1'b0;
			w_seen_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_hold_r <= 32'h0000_0000;
			s_bvalid <= 1'b0;
			s_bresp <= `FBH_RESP_OKAY;
			ctrl_r <= 7'h04;
			addr_r <= 19'h0_0000;
			wdata_r <= 16'h0000;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_seen_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_seen_r <= 1'b1;
				wdata_hold_r <= s_wdata;
			end
			// The go bit clears itself once the cycle has been launched.
			if (state_r == ST_IDLE && ctrl_r[`FBH_CTRL_GO]) begin
				ctrl_r[`FBH_CTRL_GO] <= 1'b0;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
			if (wr_fire) begin
				aw_seen_r <= 1'b0;
				w_seen_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= `FBH_RESP_OKAY;
				case (awaddr_r)
				`FBH_REG_CTRL: begin
					// A write while busy is refused so a running cycle keeps its pins.
					if (busy) begin
						s_bresp <= `FBH_RESP_SLVERR;
					end else begin
						ctrl_r <= wdata_hold_r[6:0];
					end
				end
				`FBH_REG_ADDR: begin
					addr_r <= wdata_hold_r[18:0];
				end
				`FBH_REG_WDATA: begin
					wdata_r <= wdata_hold_r[15:0];
				end
				`FBH_REG_RDATA, `FBH_REG_STATUS: begin
					s_bresp <= `FBH_RESP_OKAY;
				end
				default: begin
					s_bresp <= `FBH_RESP_SLVERR;
				end
				endcase
			end
		end
	end
	// AXI read channel: one cycle from address to data.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= `FBH_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= `FBH_RESP_OKAY;
			case (s_araddr)
			`FBH_REG_CTRL: s_rdata <= {25'h000_0000, ctrl_r};
			`FBH_REG_ADDR: s_rdata <= {13'h0000, addr_r};
			`FBH_REG_WDATA: s_rdata <= {16'h0000, wdata_r};
			// Status and codes arrive on the low byte; upper byte matters only in word mode.
			`FBH_REG_RDATA: s_rdata <= {16'h0000, rdata_r};
			`FBH_REG_STATUS: s_rdata <= {31'h0000_0000, busy};
			default: begin
				s_rdata <= 32'h0000_0000;
				s_rresp <= `FBH_RESP_SLVERR;
			end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
	// Pin sequencer: one strobe of PULSE_CYC + 1 clocks per request.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			cnt_r <= 16'h0000;
			rdata_r <= 16'h0000;
			chip_select_n <= 1'b1;
			output_enable_n <= 1'b1;
			write_strobe_n <= 1'b1;
			hw_reset_n <= 1'b1;
			high_identification_voltage <= 1'b0;
			width_select_n <= 1'b1;
			flash_addr <= 18'h0_0000;
			dq_out <= 15'h0000;
			dq_oe <= 15'h0000;
			dq15_or_lsb_addr_out <= 1'b0;
			dq15_or_lsb_addr_oe <= 1'b0;
		end else begin
			width_select_n <= word_mode;
			// The extra low address bit rides on pin fifteen in byte mode.
			if (!word_mode) begin
				dq15_or_lsb_addr_out <= addr_r[0];
				dq15_or_lsb_addr_oe <= 1'b1;
			end
			case (state_r)
			ST_IDLE: begin
				// Between cycles the device is left in standby with data pins released.
				chip_select_n <= 1'b1;
				output_enable_n <= 1'b1;
				write_strobe_n <= 1'b1;
				hw_reset_n <= 1'b1;
				high_identification_voltage <= 1'b0;
				dq_oe <= 15'h0000;
				if (word_mode) begin
					dq15_or_lsb_addr_oe <= 1'b0;
				end
				if (ctrl_r[`FBH_CTRL_GO]) begin
					state_r <= ST_PULSE;
					cnt_r <= PULSE_CYC[15:0];
					flash_addr <= addr_r[18:1];
					if (ctrl_r[`FBH_CTRL_RESET]) begin
						// Reset pulse returns the device to read-array.
						hw_reset_n <= 1'b0;
					end else if (ctrl_r[`FBH_CTRL_PROT] || ctrl_r[`FBH_CTRL_UNPROT]) begin
						chip_select_n <= 1'b0;
						write_strobe_n <= 1'b0;
						high_identification_voltage <= 1'b1;
						flash_addr[`FBH_ADDR_A6 - 1] <= ctrl_r[`FBH_CTRL_UNPROT];
						flash_addr[`FBH_ADDR_A1 - 1] <= 1'b1;
						flash_addr[`FBH_ADDR_A0 - 1] <= 1'b0;
						// The protect cycle is a write cycle, so the data lanes are driven as for one.
						dq_out <= wdata_r[14:0];
						dq_oe <= word_mode ? 15'h7fff : 15'h00ff;
						if (word_mode) begin
							dq15_or_lsb_addr_out <= wdata_r[15];
							dq15_or_lsb_addr_oe <= 1'b1;
						end
					end else if (ctrl_r[`FBH_CTRL_WRITE]) begin
						// Each command cycle, bypass and erase steps are single writes.
						chip_select_n <= 1'b0;
						write_strobe_n <= 1'b0;
						high_identification_voltage <= ctrl_r[`FBH_CTRL_HV];
						dq_out <= wdata_r[14:0];
						dq_oe <= word_mode ? 15'h7fff : 15'h00ff;
						if (word_mode) begin
							dq15_or_lsb_addr_out <= wdata_r[15];
							dq15_or_lsb_addr_oe <= 1'b1;
						end
					end else begin
						// Plain read; the array answers without any command.
						chip_select_n <= 1'b0;
						output_enable_n <= 1'b0;
						high_identification_voltage <= ctrl_r[`FBH_CTRL_HV];
					end
				end
			end
			ST_PULSE: begin
				if (cnt_r <= 16'h0001) begin
					state_r <= ST_DONE;
					if (!output_enable_n) begin
						rdata_r <= word_mode ? {dq15_or_lsb_addr_in, dq_in} : {8'h00, dq_in[7:0]};
					end
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			ST_DONE: begin
				// Strobes rise first; address and data stay one more clock for hold.
				write_strobe_n <= 1'b1;
				output_enable_n <= 1'b1;
				hw_reset_n <= 1'b1;
				chip_select_n <= 1'b1;
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // fbh_host
`default_nettype wire

// file: testbench/fbh_host_monitor.sv
// Purpose: Bus checker for the flash host pins.
// Assumes: Bound to fbh_host; one clock.
// Notes: Watches design outputs only.
`timescale 1ns/1ps
`default_nettype none
module fbh_host_monitor #(parameter PULSE_CYC = 30) (
	input wire aclk,
	input wire aresetn,
	input wire [17:0] flash_addr,
	input wire chip_select_n,
	input wire output_enable_n,
	input wire write_strobe_n,
	input wire hw_reset_n,
	input wire high_identification_voltage,
	input wire width_select_n,
	input wire [14:0] dq_oe,
	input wire dq15_or_lsb_addr_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int lo_r; // Cycles the write strobe has been low.
	// Counts the strobe width so its length can be checked at release.
	always @(posedge aclk) begin
		if (!aresetn)
			lo_r <= 0;
		else
			lo_r <= write_strobe_n ? 0 : lo_r + 1;
	end
	rd_levels_a: assert property (!output_enable_n |-> !chip_select_n && write_strobe_n && dq_oe == 15'h0)
		else $error("read cycle levels wrong");
	wr_levels_a: assert property (!write_strobe_n |-> !chip_select_n && output_enable_n)
		else $error("write cycle levels wrong");
	// The sequencer holds its strobe for the count plus the launch clock.
	pulse_len_a: assert property ($rose(write_strobe_n) |-> lo_r == PULSE_CYC + 1)
		else $error("strobe width wrong");
	addr_hold_a: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(flash_addr))
		else $error("address moved in cycle");
	word_drive_a: assert property (!write_strobe_n && width_select_n |-> dq_oe == 15'h7fff && dq15_or_lsb_addr_oe)
		else $error("word lanes not driven");
	byte_drive_a: assert property (!width_select_n |-> dq15_or_lsb_addr_oe && (write_strobe_n || dq_oe == 15'h00ff))
		else $error("byte lanes wrong");
	// Reads under high voltage are legal, but never a read and a write strobe together.
	hv_reset_a: assert property (high_identification_voltage |-> hw_reset_n && (output_enable_n || write_strobe_n))
		else $error("high voltage with reset low");
	cover property ($rose(write_strobe_n));
	cover property (high_identification_voltage && !write_strobe_n);
	cover property ($fell(hw_reset_n));
endmodule // fbh_host_monitor
`default_nettype wire

// file: testbench/fbh_flash_model.sv
// Purpose: Behavioural flash device on the far side.
// Assumes: Pins sampled on aclk for bookkeeping.
// Notes: Undriven data lanes toggle every cycle.
`timescale 1ns/1ps
`default_nettype none
module fbh_flash_model (
	input wire aclk,
	input wire [17:0] flash_addr,
	input wire chip_select_n,
	input wire output_enable_n,
	input wire write_strobe_n,
	input wire hw_reset_n,
	input wire high_identification_voltage,
	input wire width_select_n,
	input wire [15:0] dq,
	output logic [15:0] dev_q,
	output var int pcnt,
	output var int rcnt,
	output var logic pa6
);
	logic [15:0] mem [0:255]; // Array, ready to read from power-up.
	logic tg; // Toggling level for released lanes.
	wire [15:0] w = mem[flash_addr[7:0]];
	wire [7:0] b = dq[15] ? w[15:8] : w[7:0];
	wire en = !chip_select_n && !output_enable_n && write_strobe_n && hw_reset_n;
	wire [15:0] ln = en ? (width_select_n ? 16'hffff : 16'h00ff) : 16'h0;
	assign dev_q = ln & (width_select_n ? w : {8'h00, b}) | ~ln & {16{tg}};
	initial begin
		tg = 0;
		pcnt = 0;
		rcnt = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = {i[7:0], ~i[7:0]};
	end
	// Write cycles land in the protect counter and A6 record, or the array.
	always @(posedge aclk) begin
		tg <= ~tg;
		if (!chip_select_n && !write_strobe_n && output_enable_n && hw_reset_n) begin
			if (high_identification_voltage && flash_addr[1] && !flash_addr[0]) begin
				pcnt <= pcnt + 1;
				pa6 <= flash_addr[6];
			end else if (width_select_n)
				mem[flash_addr[7:0]] <= dq;
			else if (dq[15])
				mem[flash_addr[7:0]][15:8] <= dq[7:0];
			else
				mem[flash_addr[7:0]][7:0] <= dq[7:0];
		end
	end
	always @(negedge hw_reset_n) rcnt++;
endmodule // fbh_flash_model
`default_nettype wire

// file: testbench/fbh_host_tb.sv
// Purpose: Self-checking bench for fbh_host.
// Assumes: Short strobe via PULSE_CYC.
// Notes: Reads back through the model.
`timescale 1ns/1ps
`default_nettype none
module fbh_host_tb;
	localparam int P = 8;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pa6;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, rd, d;
	logic [3:0] s_wstrb;
	logic [1:0] resp;
	logic [17:0] a;
	wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, chip_select_n, output_enable_n, write_strobe_n;
	wire hw_reset_n, high_identification_voltage, width_select_n, dq15_or_lsb_addr_out, dq15_or_lsb_addr_oe;
	wire dq15_or_lsb_addr_in;
	wire [1:0] s_bresp, s_rresp;
	wire [31:0] s_rdata;
	wire [17:0] flash_addr;
	wire [14:0] dq_in, dq_out, dq_oe;
	wire [15:0] dev_q;
	int miscompares, check_count, pcnt, rcnt, n;
	assign dq_in = dq_oe & dq_out | ~dq_oe & dev_q[14:0];
	assign dq15_or_lsb_addr_in = dq15_or_lsb_addr_oe ? dq15_or_lsb_addr_out : dev_q[15];
	fbh_host #(.PULSE_CYC(P)) i_fbh_host (.*);
	fbh_flash_model i_fbh_flash_model (.dq({dq15_or_lsb_addr_in, dq_in}), .*);
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Power-up content of the model's array at one index.
	function automatic logic [15:0] init_word(input logic [7:0] ix);
		return {ix, ~ix};
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// AXI write: both channels offered together, bready held until bvalid.
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge aclk);
		s_awaddr <= ad;
		s_wdata <= dt;
		{s_awvalid, s_wvalid, s_bready} <= 3'b111;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 0;
			if (s_wready) s_wvalid <= 0;
			if (s_bvalid) break;
		end
		resp = s_bresp;
		s_bready <= 0;
		if (n == 99) chk("write timeout", 0, 1);
		if (n == 99) close_out;
	endtask
	task rdr(input logic [7:0] ad);
		@(posedge aclk);
		s_araddr <= ad;
		{s_arvalid, s_rready} <= 2'b11;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 0;
			if (s_rvalid) break;
		end
		{rd, resp} = {s_rdata, s_rresp};
		s_rready <= 0;
		if (n == 99) chk("read timeout", 0, 1);
		if (n == 99) close_out;
	endtask
	task idle;
		int k;
		for (k = 0; k < 40; k++) begin
			rdr(8'h10);
			if (rd[0] === 1'b0) break;
		end
		if (k == 40) chk("busy timeout", 0, 1);
		if (k == 40) close_out;
	endtask
	task op(input logic [31:0] c);
		wr(8'h00, c);
		idle;
	endtask
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, aresetn} = 6'h0;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0000_0000_000f;
		{miscompares, check_count} = 0;
		n = $urandom(33615);
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rdr(8'h00);
		chk("ctrl reset", rd, 32'h4);
		rdr(8'h14);
		chk("unmapped", {rd, resp}, 2'b10);
		repeat (6) begin
			a = $urandom;
			d = $urandom;
			wr(8'h04, {a[17:8], 1'b1, a[6:0], 1'b0});
			op(5);
			rdr(8'h0c);
			chk("word read", rd[15:0], init_word({1'b1, a[6:0]}));
			wr(8'h04, {a[17:8], 1'b0, a[6:0], 1'b0});
			wr(8'h08, d);
			op(7);
			op(5);
			rdr(8'h0c);
			chk("word write", rd[15:0], d[15:0]);
		end
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, 32'h20 + i);
			wr(8'h08, d >> (8 * i));
			op(3);
		end
		op(1);
		rdr(8'h0c);
		chk("byte read", rd[7:0], d[15:8]);
		op(32'h25);
		// The strobe spans the count plus the launch clock, and the model counts each clock.
		chk("protect", {pcnt, pa6}, {P + 1, 1'b0});
		op(32'h45);
		chk("unprotect", {pcnt, pa6}, {2 * P + 2, 1'b1});
		op(32'h15);
		chk("reset", rcnt, 1);
		wr(8'h04, 32'h20);
		op(5);
		rdr(8'h0c);
		chk("array after reset", rd[15:0], d[15:0]);
		// Write and read back under the high voltage, away from the protect address pattern.
		wr(8'h08, ~d);
		op(32'h0f);
		op(32'h0d);
		rdr(8'h0c);
		chk("temp unprotect", rd[15:0] ^ d[15:0], 32'h0000_ffff);
		wr(8'h00, 5);
		wr(8'h00, 5);
		chk("busy refuse", resp, 2'b10);
		idle;
		close_out;
	end
endmodule // fbh_host_tb
bind fbh_host fbh_host_monitor #(.PULSE_CYC(PULSE_CYC)) i_mon (.*);
`default_nettype wire
